/* wdt_pkg.sv */
// package: register layout, keys and prescaler width for the watchdog interval timer
package wdt_pkg;
  // register selects on the documented word port
  localparam logic [0:0] SEL_COUNT  = 1'h0;
  localparam logic [0:0] SEL_CTRL   = 1'h1;
  // access size codes
  localparam logic [1:0] SIZE_BYTE  = 2'h0;
  localparam logic [1:0] SIZE_WORD  = 2'h1;
  localparam logic [1:0] SIZE_LONG  = 2'h2;
  // write keys carried in the upper byte
  localparam logic [7:0] KEY_COUNT  = 8'h5A;
  localparam logic [7:0] KEY_CTRL   = 8'hA5;
  // control/status field positions
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_MODE     = 6;
  localparam int BIT_RSTSEL   = 5;
  localparam int BIT_WATCHDOG_OVERFLOW_FLAG     = 4;
  localparam int BIT_INTERVAL_OVERFLOW_FLAG     = 3;
  localparam int DIV_HI       = 2;
  // reset values and count landmarks
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET  = 8'h00;
  localparam logic [7:0] CNT_TOP    = 8'hFF;
  localparam logic [7:0] CNT_ZERO   = 8'h00;
  localparam logic [7:0] CNT_REENTER = 8'h80;
  // prescaler width: largest ratio is 1/4096
  localparam int PRE_W = 12;
endpackage

/* wdt_prescaler.sv */
// prescaler: divider counting only while running, giving a one-cycle tick at the selected ratio
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  // control
  input  wire logic             run_in,
  input  wire logic             restart_in,
  input  wire logic [DIV_HI:0]  div_sel_in,
  // tick
  output logic                  tick_out
);
  logic [PRE_W-1:0] pre_ff;
  logic [PRE_W-1:0] nxt_pre;
  logic [PRE_W-1:0] mask;

  // ratio mask for each divider code: tick when masked bits are all ones
  function automatic logic [PRE_W-1:0] div_mask(input logic [DIV_HI:0] sel);
    case (sel)
      3'h0:    div_mask = 12'h000;
      3'h1:    div_mask = 12'h003;
      3'h2:    div_mask = 12'h00F;
      3'h3:    div_mask = 12'h01F;
      3'h4:    div_mask = 12'h03F;
      3'h5:    div_mask = 12'h0FF;
      3'h6:    div_mask = 12'h3FF;
      default: div_mask = 12'hFFF;
    endcase
  endfunction

  assign mask     = div_mask(div_sel_in);
  assign tick_out = run_in && ((pre_ff & mask) == mask);

  // count only while running; a restart gives the documented timer variation
  always_comb
  begin
    nxt_pre = pre_ff;
    if (restart_in || !run_in)
      nxt_pre = '0;
    else
      nxt_pre = pre_ff + 12'h001;
  end

  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      pre_ff <= '0;
    else
      pre_ff <= nxt_pre;
  end
endmodule
`default_nettype wire

/* wdt_interval_timer.sv */
// watchdog / interval timer with keyed word writes and oscillator settling timing
// Function
// - three-bit select picks eight divider ratios
// - interval overflow sets interval flag
// - only word writes reach counter/control
// - counter write needs key 5A upper
// - control write needs key A5 upper
// - reset-cancelled standby: timer does not run
// - standby: count starts on nmi edge
// - settling overflow resumes clock generator
// - settling overflow leaves watchdog flag alone
// - continue from 00; re-standby at 80
// - clearing standby select after settling stops counting while enable is low
// - re-entered standby leaves only by power-on
// - frequency write halts cpu, starts timer
// - frequency overflow resumes clock, no flag
// - after frequency overflow counter holds 00 while enable is low
// - watchdog overflow sets flag, issues reset
// - interval overflow requests interrupt, continues
// - enable low freezes counter outside settle phases
// - reaching FF counts as overflow
`timescale 1ns/1ps
`default_nettype none
module wdt_interval_timer
  import wdt_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        nrst_in,
  // register port
  input  wire logic        wr_in,
  input  wire logic [0:0]  reg_sel_in,
  input  wire logic [1:0]  size_in,
  input  wire logic [15:0] wdata_in,
  output logic [7:0]       count_rd_out,
  output logic [7:0]       ctrl_rd_out,
  // power management
  input  wire logic        nmi_in,
  input  wire logic        standby_sel_in,
  input  wire logic        standby_stopped_in,
  input  wire logic        freq_write_in,
  // clock generator, reset and interrupt requests
  output logic             cpu_halt_out,
  output logic             clock_resume_out,
  output logic             standby_reenter_out,
  output logic             por_req_out,
  output logic             manual_rst_req_out,
  output logic             interval_irq_out
);
  typedef enum logic [3:0] {
    ST_NORMAL = 4'b0001,
    ST_SETTLE = 4'b0010,
    ST_POSTSB = 4'b0100,
    ST_LOCKED = 4'b1000
  } phase_t;

  phase_t     phase_ff, nxt_phase;
  logic       freq_ff, nxt_freq;
  logic [7:0] cnt_ff, nxt_cnt;
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic       por_ff, nxt_por;
  logic       mrst_ff, nxt_mrst;
  logic       irq_ff, nxt_irq;
  logic       resume_ff, nxt_resume;
  logic       reent_ff, nxt_reent;
  logic       nmi_s1_ff, nmi_s2_ff, nmi_d_ff;
  logic       nmi_edge, word_wr, cnt_wr, ctrl_wr, run, ovf, tick;

  // nmi pin synchroniser, edge taken from the second stage only
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      nmi_s1_ff <= 1'b0;
      nmi_s2_ff <= 1'b0;
      nmi_d_ff  <= 1'b0;
    end
    else
    begin
      nmi_s1_ff <= nmi_in;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_d_ff  <= nmi_s2_ff;
    end
  end
  assign nmi_edge = nmi_s2_ff ^ nmi_d_ff;

  assign word_wr = wr_in && (size_in == SIZE_WORD);
  assign cnt_wr  = word_wr && (reg_sel_in == SEL_COUNT) && (wdata_in[15:8] == KEY_COUNT);
  assign ctrl_wr = word_wr && (reg_sel_in == SEL_CTRL) && (wdata_in[15:8] == KEY_CTRL);

  // enable gates counting; settle phases count on their own
  assign run = ctrl_ff[BIT_ENABLE] || (phase_ff == ST_SETTLE) || (phase_ff == ST_POSTSB);

  wdt_prescaler u_pre (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .run_in      (run),
    .restart_in  (cnt_wr),
    .div_sel_in  (ctrl_ff[DIV_HI:0]),
    .tick_out    (tick)
  );

  // reaching FF is the overflow, independent of the tick
  assign ovf = run && (cnt_ff == CNT_TOP) && !cnt_wr;

  // counter, control and phase next-state
  always_comb
  begin
    nxt_phase  = phase_ff;
    nxt_freq   = freq_ff;
    nxt_cnt    = cnt_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_por    = 1'b0;
    nxt_mrst   = 1'b0;
    nxt_irq    = 1'b0;
    nxt_resume = 1'b0;
    nxt_reent  = reent_ff;
    if (run && tick && !ovf)
      nxt_cnt = cnt_ff + 8'h01;
    case (phase_ff)
      ST_NORMAL:
      begin
        // nmi edge in stopped standby starts settling count
        if (standby_stopped_in && nmi_edge)
        begin
          nxt_phase = ST_SETTLE;
          nxt_freq  = 1'b0;
        end
        else if (freq_write_in)
        begin
          nxt_phase = ST_SETTLE;
          nxt_freq  = 1'b1;
        end
        else if (ovf)
        begin
          nxt_cnt = CNT_ZERO;
          if (ctrl_ff[BIT_MODE])
          begin
            nxt_ctrl[BIT_WATCHDOG_OVERFLOW_FLAG] = 1'b1;
            nxt_por  = !ctrl_ff[BIT_RSTSEL];
            nxt_mrst = ctrl_ff[BIT_RSTSEL];
          end
          else
          begin
            nxt_ctrl[BIT_INTERVAL_OVERFLOW_FLAG] = 1'b1;
            nxt_irq = 1'b1;
          end
        end
      end
      ST_SETTLE:
      begin
        if (ovf)
        begin
          nxt_cnt    = CNT_ZERO;
          nxt_resume = 1'b1;
          nxt_phase  = freq_ff ? ST_NORMAL : ST_POSTSB;
        end
      end
      ST_POSTSB:
      begin
        if (!standby_sel_in)
          nxt_phase = ST_NORMAL;
        else if (cnt_ff == CNT_REENTER)
        begin
          nxt_phase = ST_LOCKED;
          nxt_reent = 1'b1;
        end
      end
      // only a power-on reset leaves this phase
      default: nxt_phase = ST_LOCKED;
    endcase
    // writes land only with the matching key
    if (cnt_wr)
      nxt_cnt = wdata_in[7:0];
    if (ctrl_wr)
    begin
      nxt_ctrl = wdata_in[7:0];
      // set wins over a clear in the same cycle
      if (nxt_por || nxt_mrst)
        nxt_ctrl[BIT_WATCHDOG_OVERFLOW_FLAG] = 1'b1;
      if (nxt_irq)
        nxt_ctrl[BIT_INTERVAL_OVERFLOW_FLAG] = 1'b1;
    end
  end

  // reset clears every phase, so the timer is idle after reset
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      phase_ff  <= ST_NORMAL;
      freq_ff   <= 1'b0;
      cnt_ff    <= CNT_RESET;
      ctrl_ff   <= CTRL_RESET;
      por_ff    <= 1'b0;
      mrst_ff   <= 1'b0;
      irq_ff    <= 1'b0;
      resume_ff <= 1'b0;
      reent_ff  <= 1'b0;
    end
    else
    begin
      phase_ff  <= nxt_phase;
      freq_ff   <= nxt_freq;
      cnt_ff    <= nxt_cnt;
      ctrl_ff   <= nxt_ctrl;
      por_ff    <= nxt_por;
      mrst_ff   <= nxt_mrst;
      irq_ff    <= nxt_irq;
      resume_ff <= nxt_resume;
      reent_ff  <= nxt_reent;
    end
  end

  // outputs
  assign count_rd_out        = cnt_ff;
  assign ctrl_rd_out         = ctrl_ff;
  assign por_req_out         = por_ff;
  assign manual_rst_req_out  = mrst_ff;
  assign interval_irq_out    = irq_ff;
  assign clock_resume_out    = resume_ff;
  assign standby_reenter_out = reent_ff;
  // halt held while a frequency change settles
  assign cpu_halt_out = (phase_ff == ST_SETTLE) && freq_ff;

  // assertions
  bad_key_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (wr_in && wdata_in[15:8] != KEY_COUNT && !run)
    |=> $stable(cnt_ff))
    else $error("counter changed on unkeyed write");
  byte_wr_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (wr_in && size_in != SIZE_WORD && phase_ff == ST_NORMAL && !ovf && !freq_write_in)
    |=> $stable(ctrl_ff))
    else $error("control changed on non-word write");
  cnt_load_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    cnt_wr |=> cnt_ff == $past(wdata_in[7:0]))
    else $error("keyed counter write not loaded");
  ctrl_load_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ctrl_wr && !ovf) |=> ctrl_ff == $past(wdata_in[7:0]))
    else $error("keyed control write not loaded");
  stop_hold_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (!run && !cnt_wr) |=> cnt_ff == $past(cnt_ff))
    else $error("counter moved while stopped");
  iv_ovf_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ovf && phase_ff == ST_NORMAL && !ctrl_ff[BIT_MODE] && !freq_write_in
     && !(standby_stopped_in && nmi_edge))
    |=> interval_irq_out && ctrl_ff[BIT_INTERVAL_OVERFLOW_FLAG] && !por_req_out)
    else $error("interval overflow missed");
  wd_ovf_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ovf && phase_ff == ST_NORMAL && ctrl_ff[BIT_MODE] && !freq_write_in
     && !(standby_stopped_in && nmi_edge))
    |=> ctrl_ff[BIT_WATCHDOG_OVERFLOW_FLAG] && (por_req_out != manual_rst_req_out))
    else $error("watchdog overflow missed");
  settle_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ovf && phase_ff == ST_SETTLE && !ctrl_wr)
    |=> clock_resume_out && $stable(ctrl_ff[BIT_WATCHDOG_OVERFLOW_FLAG]))
    else $error("settle overflow wrong");
  freq_stop_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    (ovf && phase_ff == ST_SETTLE && freq_ff && !cnt_wr) |=> cnt_ff == CNT_ZERO)
    else $error("counter not zero after frequency change");
  locked_a: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
    phase_ff == ST_LOCKED |=> phase_ff == ST_LOCKED && standby_reenter_out)
    else $error("left re-entered standby");
  cv_iv: cover property (@(posedge core_clk_in) disable iff (!nrst_in) interval_irq_out);
  cv_wd: cover property (@(posedge core_clk_in) disable iff (!nrst_in) por_req_out);
  cv_res: cover property (@(posedge core_clk_in) disable iff (!nrst_in) clock_resume_out);
  cv_lock: cover property (@(posedge core_clk_in) disable iff (!nrst_in) standby_reenter_out);
endmodule
`default_nettype wire

/* wdt_far_model.sv */
// far-side model: clock generator view of standby entry, resume and relock
`timescale 1ns/1ps
`default_nettype none
module wdt_far_model
(
  // clock and reset
  input  wire logic core_clk_in,
  input  wire logic nrst_in,
  // standby request and timer outputs
  input  wire logic enter_in,
  input  wire logic clock_resume_in,
  input  wire logic standby_reenter_in,
  // clock stopped state
  output logic      stopped_out
);
  logic stopped_ff;
  logic nxt_stopped;
  // next stopped state; relock wins so a late resume cannot undo it
  always_comb
  begin
    nxt_stopped = stopped_ff;
    if (enter_in)
      nxt_stopped = 1'b1;
    if (clock_resume_in)
      nxt_stopped = 1'b0;
    if (standby_reenter_in)
      nxt_stopped = 1'b1;
  end
  // register only
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      stopped_ff <= 1'b0;
    else
      stopped_ff <= nxt_stopped;
  end
  assign stopped_out = stopped_ff;
endmodule
`default_nettype wire

/* tb.sv */
// self-checking testbench for the watchdog interval timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  import wdt_pkg::*;
  typedef struct packed {logic [0:0] sel; logic [1:0] size; logic [15:0] data;
    logic [7:0] cnt; logic [7:0] ctrl;} row_t;
  logic clk = 0, nrst = 0, wr = 0, nmi = 0, sby = 0, fwr = 0, enter = 0;
  logic [0:0]  sel = 0;
  logic [1:0]  size = 0;
  logic [15:0] wdata = 0;
  logic [7:0]  cnt, ctrl, last;
  logic        halt, resume, relock, por, man, irq, stopped;
  int          fail_count = 0, checked = 0, n;
  int          ratio [8] = '{1, 4, 16, 32, 64, 256, 1024, 4096};
  row_t        rows [10] = '{'{1'h0, SIZE_WORD, 16'h5A10, 8'h10, 8'h00},
    '{1'h0, SIZE_BYTE, 16'h5A20, 8'h10, 8'h00}, '{1'h0, SIZE_LONG, 16'h5A20, 8'h10, 8'h00},
    '{1'h0, SIZE_WORD, 16'hA530, 8'h10, 8'h00}, '{1'h1, SIZE_WORD, 16'hA507, 8'h10, 8'h07},
    '{1'h1, SIZE_WORD, 16'h5A01, 8'h10, 8'h07}, '{1'h1, SIZE_BYTE, 16'hA502, 8'h10, 8'h07},
    '{1'h1, SIZE_LONG, 16'hA503, 8'h10, 8'h07}, '{1'h0, SIZE_WORD, 16'h3C40, 8'h10, 8'h07},
    '{1'h1, SIZE_WORD, 16'h3C40, 8'h10, 8'h07}};
  wdt_interval_timer dut (.core_clk_in(clk), .nrst_in(nrst), .wr_in(wr), .reg_sel_in(sel),
    .size_in(size), .wdata_in(wdata), .count_rd_out(cnt), .ctrl_rd_out(ctrl), .nmi_in(nmi),
    .standby_sel_in(sby), .standby_stopped_in(stopped), .freq_write_in(fwr),
    .cpu_halt_out(halt), .clock_resume_out(resume), .standby_reenter_out(relock),
    .por_req_out(por), .manual_rst_req_out(man), .interval_irq_out(irq));
  wdt_far_model far (.core_clk_in(clk), .nrst_in(nrst), .enter_in(enter),
    .clock_resume_in(resume), .standby_reenter_in(relock), .stopped_out(stopped));
  // 200 MHz clock
  always #2.5 clk = ~clk;
  task automatic tally_and_finish();
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // all tasks start and end 1 ns after a rising edge
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [0:0] s, input logic [1:0] z, input logic [15:0] d);
    sel = s;
    size = z;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return irq;
      1: return por;
      2: return man;
      3: return resume;
      4: return relock;
      default: return cnt !== last;
    endcase
  endfunction
  // bounded wait; pulses stand one cycle so every cycle is sampled
  task automatic wait_sig(input int w, input int lim, output int k);
    k = 0;
    while (sig(w) !== 1'b1)
    begin
      cyc(1);
      k++;
      if (k > lim)
      begin
        fail_count++;
        tally_and_finish();
      end
    end
  endtask
  task automatic standby(input bit keep);
    wr_reg(SEL_COUNT, SIZE_WORD, 16'h5AF0);
    sby = 1'b1;
    enter = 1'b1;
    cyc(1);
    enter = 1'b0;
    cyc(2);
    nmi = ~nmi;
    wait_sig(3, 60, n);
    chk("ctrl", 16'(ctrl), 16'h0000);
    if (keep)
    begin
      wait_sig(4, 200, n);
      chk("relock_time", 16'(n >= 124 && n <= 132), 16'h0001);
      sby = 1'b0;
      cyc(5);
      chk("relock", 16'(relock), 16'h0001);
      chk("stopped", 16'(stopped), 16'h0001);
    end
    else
    begin
      cyc(4);
      sby = 1'b0;
      cyc(3);
      last = cnt;
      cyc(8);
      chk("count", 16'(cnt), 16'(last));
    end
  endtask
  initial
  begin
    cyc(3);
    nrst = 1'b1;
    cyc(1);
    chk("count", 16'(cnt), 16'h0000);
    chk("ctrl", 16'(ctrl), 16'h0000);
    for (int i = 0; i < 10; i++)
    begin
      wr_reg(rows[i].sel, rows[i].size, rows[i].data);
      cyc(1);
      chk("count", 16'(cnt), 16'(rows[i].cnt));
      chk("ctrl", 16'(ctrl), 16'(rows[i].ctrl));
    end
    // divider ratios measured as cycles between two counter steps
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(SEL_CTRL, SIZE_WORD, 16'hA500);
      wr_reg(SEL_CTRL, SIZE_WORD, {KEY_CTRL, 5'h00, 3'(c)});
      wr_reg(SEL_COUNT, SIZE_WORD, 16'h5A00);
      wr_reg(SEL_CTRL, SIZE_WORD, {KEY_CTRL, 5'h10, 3'(c)});
      last = cnt;
      wait_sig(5, 9000, n);
      last = cnt;
      wait_sig(5, 5000, n);
      chk("tick", 16'(n), 16'(ratio[c]));
    end
    wr_reg(SEL_CTRL, SIZE_WORD, 16'hA500);
    wr_reg(SEL_COUNT, SIZE_WORD, 16'h5AFD);
    wr_reg(SEL_CTRL, SIZE_WORD, 16'hA580);
    wait_sig(0, 20, n);
    cyc(1);
    chk("ctrl", 16'(ctrl), 16'h0088);
    wr_reg(SEL_CTRL, SIZE_WORD, 16'hA500);
    wr_reg(SEL_CTRL, SIZE_WORD, 16'hA507);
    wr_reg(SEL_CTRL, SIZE_WORD, 16'hA587);
    wr_reg(SEL_COUNT, SIZE_WORD, 16'h5AFF);
    wait_sig(0, 3, n);
    chk("ovf_delay", 16'(n), 16'h0000);
    // watchdog mode, both reset kinds
    for (int r = 0; r < 2; r++)
    begin
      wr_reg(SEL_CTRL, SIZE_WORD, 16'hA500);
      wr_reg(SEL_COUNT, SIZE_WORD, 16'h5AFD);
      wr_reg(SEL_CTRL, SIZE_WORD, {KEY_CTRL, 2'h3, 1'(r), 5'h00});
      wait_sig(1 + r, 20, n);
      cyc(1);
      chk("ctrl", 16'(ctrl), {8'h00, 2'h3, 1'(r), 5'h10});
    end
    wr_reg(SEL_CTRL, SIZE_WORD, 16'hA500);
    wr_reg(SEL_COUNT, SIZE_WORD, 16'h5AF0);
    // pll change timed by the timer
    fwr = 1'b1;
    cyc(1);
    fwr = 1'b0;
    cyc(1);
    chk("halt", 16'(halt), 16'h0001);
    wait_sig(3, 40, n);
    cyc(20);
    chk("count", 16'(cnt), 16'h0000);
    chk("ctrl", 16'(ctrl), 16'h0000);
    chk("halt", 16'(halt), 16'h0000);
    standby(1'b0);
    standby(1'b1);
    nrst = 1'b0;
    cyc(2);
    nrst = 1'b1;
    cyc(1);
    chk("relock", 16'(relock), 16'h0000);
    chk("stopped", 16'(stopped), 16'h0000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
